// ---- shared/nic_pkg.sv ----
// Package of constants and types shared by the interrupt controller and its CPU-side partner
package nic_pkg;
	// ==========================================================
	// Sizes and vectors
	localparam int NIC_NUM_SRC = 4;
	localparam int NIC_VEC_W = 8;
	localparam logic [7:0] NIC_VEC_RESET = 8'hFF;
	localparam logic [7:0] NIC_VEC_BASE = 8'h10;
	localparam int NIC_BLACKOUT_CYC = 1;
	// ==========================================================
	// Edge sensitivity encoding, two bits per line
	typedef enum logic [1:0] {
		NIC_SENS_FALL = 2'h0,
		NIC_SENS_RISE = 2'h1,
		NIC_SENS_BOTH = 2'h2,
		NIC_SENS_NONE = 2'h3
	} nic_sens_type;
endpackage : nic_pkg

// ---- shared/nic_if.sv ----
// Interface joining the interrupt controller and the CPU core
`timescale 1ns/10ps
`default_nettype none
interface nic_if;
	import nic_pkg::*;
	logic [NIC_NUM_SRC-1:0] irq_pending;
	logic irq_req;
	logic [NIC_VEC_W-1:0] irq_vector;
	logic irq_ack;
	logic global_mask;
	logic cc_restore;
	logic port_cfg_access;
	logic [NIC_NUM_SRC-1:0] flag_clear;
	logic [NIC_NUM_SRC-1:0] src_enable;
	logic [NIC_NUM_SRC-1:0] in_handler;
	logic spurious_reset;
	modport ctrl (
		output irq_pending, irq_req, irq_vector, spurious_reset,
		input irq_ack, global_mask, cc_restore, port_cfg_access, flag_clear, src_enable,
		in_handler
	);
	modport cpu (
		input irq_pending, irq_req, irq_vector, spurious_reset,
		output irq_ack, global_mask, cc_restore, port_cfg_access, flag_clear, src_enable,
		in_handler
	);
endinterface : nic_if
`default_nettype wire

// ---- hdl/nic_ctrl.sv ----
// Nested interrupt controller with external-line edge detectors
`timescale 1ns/10ps
`default_nettype none
module nic_ctrl import nic_pkg::*; #(
	parameter int NUM_SRC = NIC_NUM_SRC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [NUM_SRC-1:0] ext_pin,
	input wire logic [2*NUM_SRC-1:0] ext_sens,
	nic_if.ctrl bus
);
	// ==========================================================
	// Edge detection
	logic [NUM_SRC-1:0] pin_prev_ff;
	logic [NUM_SRC-1:0] pend_ff;
	logic req_ff;
	logic [NIC_VEC_W-1:0] vec_ff;
	logic sreset_ff;
	logic [NUM_SRC-1:0] edge_hit;
	logic [NUM_SRC-1:0] nxt_pend;
	wire logic blackout = bus.port_cfg_access;
	wire logic [NUM_SRC-1:0] active = pend_ff & bus.src_enable;

	function automatic logic edge_match(input logic prev, input logic cur, input logic [1:0] s);
		logic rise;
		logic fall;
		rise = !prev && cur;
		fall = prev && !cur;
		case (s)
			NIC_SENS_FALL: edge_match = fall;
			NIC_SENS_RISE: edge_match = rise;
			NIC_SENS_BOTH: edge_match = rise || fall;
			default: edge_match = 1'b0;
		endcase
	endfunction : edge_match

	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			// Blackout drops the edge; no late catch-up, so software must recover it
			edge_hit[i] = !blackout && edge_match(pin_prev_ff[i], ext_pin[i],
				ext_sens[2*i +: 2]);
			// Set wins over clear and handler entry
			nxt_pend[i] = edge_hit[i] || (pend_ff[i] && !bus.flag_clear[i]
				&& !(bus.irq_ack && req_ff && vec_ff == vec_of(i)));
		end
	end

	function automatic logic [NIC_VEC_W-1:0] vec_of(input int idx);
		vec_of = NIC_VEC_BASE + NIC_VEC_W'(idx);
	endfunction : vec_of

	// ==========================================================
	// Priority: lowest index wins
	logic [NIC_VEC_W-1:0] nxt_vec;
	always_comb begin
		nxt_vec = NIC_VEC_RESET;
		for (int i = NUM_SRC-1; i >= 0; i--) begin
			if (active[i]) begin
				nxt_vec = vec_of(i);
			end
		end
	end

	wire logic any_req = |active && !bus.global_mask;
	// Vector lookup is lost while the condition code is restored
	wire logic [NIC_VEC_W-1:0] sel_vec = bus.cc_restore ? NIC_VEC_RESET : nxt_vec;
	// Only a pending-flag clear racing a new edge is exposed; enable clears are not
	// A clear bracketed by the global mask is safe as well
	wire logic collide = |(bus.flag_clear & edge_hit & bus.src_enable
		& ~bus.in_handler) && !bus.global_mask;

	// Pin history follows the pin through reset, so release brings no false edge
	always_ff @(posedge clk_sys) begin
		pin_prev_ff <= ext_pin;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend_ff <= '0;
			req_ff <= 1'b0;
			vec_ff <= NIC_VEC_RESET;
			sreset_ff <= 1'b0;
		end else begin
			pend_ff <= nxt_pend;
			req_ff <= any_req;
			vec_ff <= sel_vec;
			sreset_ff <= collide;
		end
	end

	assign bus.irq_pending = pend_ff;
	assign bus.irq_req = req_ff;
	assign bus.irq_vector = vec_ff;
	assign bus.spurious_reset = sreset_ff;
endmodule : nic_ctrl
`default_nettype wire

// ---- hdl/nic_cpu.sv ----
// CPU-side end: drives mask, restores, port accesses and flag clears for the controller
`timescale 1ns/10ps
`default_nettype none
module nic_cpu import nic_pkg::*; #(
	parameter int NUM_SRC = NIC_NUM_SRC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic op_set_mask,
	input wire logic op_clear_mask,
	input wire logic op_cc_restore,
	input wire logic op_port_cfg,
	input wire logic [NUM_SRC-1:0] op_flag_clear,
	input wire logic [NUM_SRC-1:0] op_enable,
	output logic took_vector,
	output logic [NIC_VEC_W-1:0] taken_vector,
	output logic saw_reset,
	nic_if.cpu bus
);
	// ==========================================================
	// Sequencer state
	typedef enum logic [1:0] {NIC_IDLE, NIC_MASKED, NIC_RESTORE} nic_cpu_state_type;
	nic_cpu_state_type state_ff;
	nic_cpu_state_type nxt_state;
	logic mask_ff;
	logic restore_ff;
	logic cfg_ff;
	logic [NUM_SRC-1:0] clr_ff;
	logic [NUM_SRC-1:0] en_ff;
	logic [NUM_SRC-1:0] hnd_ff;
	logic ack_ff;
	logic took_ff;
	logic [NIC_VEC_W-1:0] tvec_ff;
	logic rst_seen_ff;

	// Restore is only issued once the mask is set a cycle earlier
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			NIC_IDLE: if (op_cc_restore) nxt_state = NIC_MASKED;
			NIC_MASKED: nxt_state = NIC_RESTORE;
			default: nxt_state = NIC_IDLE;
		endcase
	end

	wire logic take = bus.irq_req && !ack_ff && !mask_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= NIC_IDLE;
			mask_ff <= 1'b1;
			restore_ff <= 1'b0;
			cfg_ff <= 1'b0;
			clr_ff <= '0;
			en_ff <= '0;
			hnd_ff <= '0;
			ack_ff <= 1'b0;
			took_ff <= 1'b0;
			tvec_ff <= NIC_VEC_RESET;
			rst_seen_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			// Handler entry masks, so a request still on the wire is not taken twice
			if (op_set_mask || nxt_state == NIC_MASKED || take) begin
				mask_ff <= 1'b1;
			end else if (op_clear_mask && state_ff == NIC_IDLE) begin
				mask_ff <= 1'b0;
			end
			restore_ff <= state_ff == NIC_MASKED;
			cfg_ff <= op_port_cfg;
			clr_ff <= op_flag_clear;
			en_ff <= op_enable;
			ack_ff <= take;
			hnd_ff <= take ? bus.irq_pending : (op_clear_mask ? '0 : hnd_ff);
			took_ff <= take;
			tvec_ff <= take ? bus.irq_vector : tvec_ff;
			rst_seen_ff <= bus.spurious_reset || (take && bus.irq_vector == NIC_VEC_RESET);
		end
	end

	assign bus.global_mask = mask_ff;
	assign bus.cc_restore = restore_ff;
	assign bus.port_cfg_access = cfg_ff;
	assign bus.flag_clear = clr_ff;
	assign bus.src_enable = en_ff;
	assign bus.in_handler = hnd_ff;
	assign bus.irq_ack = ack_ff;
	assign took_vector = took_ff;
	assign taken_vector = tvec_ff;
	assign saw_reset = rst_seen_ff;
endmodule : nic_cpu
`default_nettype wire

// ---- dv/nic_props.sv ----
// Checker on the wire between the controller and the CPU end
`timescale 1ns/10ps
`default_nettype none
module nic_props import nic_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] ext_pin,
	input wire logic [3:0] irq_pending,
	input wire logic irq_req,
	input wire logic [7:0] irq_vector,
	input wire logic irq_ack,
	input wire logic cc_restore,
	input wire logic port_cfg_access,
	input wire logic [3:0] flag_clear,
	input wire logic [3:0] src_enable,
	input wire logic spurious_reset
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================================
	// Assertions
	vec_reset_a: assert property (irq_req && $past(cc_restore) |-> irq_vector == NIC_VEC_RESET)
		else $error("vector not reset during restore");
	cfg_pulse_a: assert property (port_cfg_access |=> !port_cfg_access)
		else $error("blackout longer than one cycle");
	lost_edge_a: assert property (port_cfg_access && $changed(ext_pin) && irq_pending == 4'h0
		|=> irq_pending == 4'h0) else $error("edge seen in blackout");
	spur_cause_a: assert property (spurious_reset |-> $past(|flag_clear))
		else $error("reset without flag clear");
	spur_enable_a: assert property (spurious_reset |-> $past(|(flag_clear & src_enable)))
		else $error("reset from disabled source");
	req_src_a: assert property (irq_req |-> $past(|irq_pending))
		else $error("request without pending");
	pend_hold_a: assert property ((|irq_pending) && !irq_ack && flag_clear == 4'h0
		|=> (irq_pending & $past(irq_pending)) == $past(irq_pending)) else $error("pending lost");
	// ==========================================================
	// Cover
	take_c: cover property (irq_ack);
	spur_c: cover property (spurious_reset);
	blank_c: cover property (port_cfg_access && $changed(ext_pin));
endmodule : nic_props
`default_nettype wire

// ---- dv/tb_top.sv ----
// Bench joining the controller and the CPU end
`timescale 1ns/10ps
`default_nettype none
module tb_top import nic_pkg::*;;
	logic clk_sys = 0, rst = 1, m_clr = 0, m_set = 0, cc = 0, cfg = 0, took, saw;
	logic [3:0] pin = 4'hF, fc = 4'h0, en = 4'hF;
	logic [7:0] tv, vec = 8'h00;
	int n_errors = 0, comparisons = 0, n_took = 0, n_rst = 0, cyc = 0;
	nic_if bus_if ();
	nic_ctrl nic_ctrl_inst (.clk_sys, .rst, .ext_pin(pin), .ext_sens(8'h00), .bus(bus_if.ctrl));
	nic_cpu nic_cpu_inst (.clk_sys, .rst, .op_set_mask(m_set), .op_clear_mask(m_clr),
		.op_cc_restore(cc), .op_port_cfg(cfg), .op_flag_clear(fc), .op_enable(en),
		.took_vector(took), .taken_vector(tv), .saw_reset(saw), .bus(bus_if.cpu));
	nic_props nic_props_inst (.clk_sys, .rst, .ext_pin(pin), .irq_pending(bus_if.irq_pending),
		.irq_req(bus_if.irq_req), .irq_vector(bus_if.irq_vector), .irq_ack(bus_if.irq_ack),
		.cc_restore(bus_if.cc_restore), .port_cfg_access(bus_if.port_cfg_access),
		.flag_clear(bus_if.flag_clear), .src_enable(bus_if.src_enable),
		.spurious_reset(bus_if.spurious_reset));
	initial forever #5 clk_sys = ~clk_sys;
	// ==========================================================
	// Monitor and timeout
	always @(posedge clk_sys) begin
		cyc++;
		if (took) vec <= tv;
		n_took <= n_took + int'(took);
		n_rst <= n_rst + int'(saw);
		if (cyc == 2000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Op pulse, then the edge lands where the registered cfg or flag clear is on the wire, a cycle before cc_restore rises
	task automatic hit(input logic [1:0] op, input logic [3:0] f, input logic [3:0] ln);
		{cc, cfg} = op;
		fc = f;
		@(negedge clk_sys);
		{cc, cfg} = 2'h0;
		fc = 4'h0;
		pin = ~ln;
		repeat (8) @(negedge clk_sys);
		pin = 4'hF;
		repeat (2) @(negedge clk_sys);
	endtask : hit
	task automatic unmask;
		m_clr = 1;
		@(negedge clk_sys);
		m_clr = 0;
		repeat (6) @(negedge clk_sys);
	endtask : unmask
	task automatic wrap_up;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// ==========================================================
	// Scenarios
	initial begin
		repeat (20) @(negedge clk_sys);
		rst = 0;
		chk({4'h0, bus_if.irq_pending}, 8'h00);
		unmask();
		hit(2'h0, 4'h0, 4'h2);
		chk(vec, NIC_VEC_BASE + 8'h01);
		unmask();
		hit(2'h1, 4'h0, 4'h4);
		chk(n_took[7:0], 8'h01);
		chk({4'h0, bus_if.irq_pending}, 8'h00);
		hit(2'h2, 4'h0, 4'h1);
		unmask();
		chk(vec, NIC_VEC_BASE);
		unmask();
		hit(2'h0, 4'h8, 4'h8);
		chk(n_rst[7:0], 8'h01);
		unmask();
		en = 4'h7;
		hit(2'h0, 4'h8, 4'h8);
		chk(n_rst[7:0], 8'h01);
		m_set = 1;
		en = 4'hF;
		@(negedge clk_sys);
		m_set = 0;
		hit(2'h0, 4'h8, 4'h8);
		chk(n_rst[7:0], 8'h01);
		unmask();
		chk(vec, NIC_VEC_BASE + 8'h03);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
